// ===== rtl/afcp_top.sv
module afcp_top #(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic                    clk,                      // 125 MHz system clock
   input  wire logic                    srst,                     // Synchronous reset, high
   input  wire logic                    psel,                     // APB select
   input  wire logic                    penable,                  // APB access phase
   input  wire logic                    pwrite,                   // APB direction
   input  wire logic [ADDR_W-1:0]       paddr,                    // APB byte address
   input  wire logic [31:0]             pwdata,                   // APB write data
   output logic      [31:0]             prdata,                   // APB read data
   output logic                         pready,                   // APB ready
   output logic                         pslverr,                  // APB error
   input  wire logic [7:0]              pin_connect_in,           // Fabric pin switches
   input  wire logic [3:0]              bus_connect_in,           // Fabric bus switches
   input  wire logic [1:0]              switch_ctrl_in,           // Ground / temp switches
   input  wire logic                    reference_negative_in,    // Fabric reference to minus
   input  wire afcp_pkg::afcp_cfg_t     cfg_in,                   // Fabric conversion settings
   input  wire logic                    trigger_in,               // Fabric trigger
   input  wire logic                    data_hilo_sel_in,         // Output byte select
   output logic      [31:0]             switch_enable_out,        // Effective switch enables
   output logic                         reference_negative_en_out,// Reference to minus switch
   output logic                         conv_start,               // Start pulse to converter
   output afcp_pkg::afcp_conv_req_t     conv_req,                 // Settings for converter
   input  wire logic                    adc_sample_done,          // Converter sampling done
   input  wire logic                    adc_conv_done,            // Converter result ready
   input  wire logic [15:0]             adc_result,               // Converter result
   input  wire logic                    adc_sat,                  // Saturation detected
   input  wire logic                    adc_range,                // Range detected
   output logic                         sample_done_out,          // Fabric sample-done pulse
   output logic                         channel_number_valid_out, // Channel number valid
   output logic      [3:0]              channel_number_out,       // Channel number or flags
   output logic                         data_valid_out,           // Data valid
   output logic      [11:0]             data_out,                 // Result data
   output logic                         eos_out                   // End of scan
);
   import afcp_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   logic [31:0]  ctrl;
   logic [31:0]  ch0_cfg;
   logic [31:0]  sw_fw;
   logic [31:0]  sw_hw;
   logic [31:0]  st_times;
   logic [15:0]  result_q;
   logic         work_valid;
   logic         result_valid;
   logic         sat_q;
   logic         range_q;
   logic [1:0]   raw_flags;
   logic         fw_pend;
   afcp_state_t  state;
   logic [1:0]   hold_cnt;
   logic [1:0]   early_cnt;
   logic         data_phase;
   afcp_cfg_t    cfg_sync;
   afcp_cfg_t    cfg_eff;
   logic [5:0]   sync_word;
   logic         trig_eff;
   logic [31:0]  fab_sw;
   logic [31:0]  next_sw;
   logic         next_ref_neg;
   logic         fabric_mode;
   logic         start_now;
   logic         wr_en;
   logic         rd_en;
   logic [31:0]  next_prdata;
   logic         next_err;

   assign fabric_mode = ctrl[CTRL_FABRIC];
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_en = psel & penable & ~pready;

   function automatic afcp_res_t pick_res(input logic avg, input logic res_in, input logic alt);
      if (avg || !res_in)
         return AFCP_RES_12;
      else if (alt)
         return AFCP_RES_10;
      else
         return AFCP_RES_8;
   endfunction

   // One wait state, answer registered
   always_ff @(posedge clk) begin
      if (srst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= rd_en;
         prdata  <= rd_en ? next_prdata : 32'h0000_0000;
         pslverr <= rd_en & next_err;
      end
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err    = 1'b0;
      if (paddr == REG_CTRL) begin
         next_prdata = ctrl;
      end else if (paddr == REG_CH0_CFG) begin
         next_prdata = ch0_cfg;
      end else if (paddr == REG_START) begin
         next_prdata[START_FW] = fw_pend;
      end else if (paddr == REG_SW_FW) begin
         next_prdata = sw_fw;
      end else if (paddr == REG_SW_HW) begin
         next_prdata = sw_hw;
      end else if (paddr == REG_ST_TIMES) begin
         next_prdata = st_times;
      end else if (paddr == REG_WORK0) begin
         next_prdata[15:0]          = result_q;
         next_prdata[RES_VALID_BIT] = work_valid;
      end else if (paddr == REG_RESULT0) begin
         next_prdata[15:0]          = result_q;
         next_prdata[RES_SAT_BIT]   = raw_flags[FLAG_SAT];
         next_prdata[RES_RANGE_BIT] = raw_flags[FLAG_RANGE];
         next_prdata[RES_VALID_BIT] = result_valid;
      end else if (paddr == REG_SW_STATE) begin
         next_prdata = switch_enable_out;
      end else if (paddr == REG_FLAGS) begin
         next_prdata[1:0] = raw_flags;
      end else begin
         next_err = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl     <= CTRL_RST;
         ch0_cfg  <= CH0_CFG_RST;
         sw_fw    <= SW_RST;
         sw_hw    <= SW_RST;
         st_times <= ST_TIMES_RST;
      end else if (wr_en) begin
         if (paddr == REG_CTRL)
            ctrl <= pwdata;
         else if (paddr == REG_CH0_CFG)
            ch0_cfg <= pwdata;
         else if (paddr == REG_SW_FW)
            sw_fw <= pwdata;
         else if (paddr == REG_SW_HW)
            sw_hw <= pwdata;
         else if (paddr == REG_ST_TIMES)
            st_times <= pwdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         fw_pend <= 1'b0;
      else if (wr_en && paddr == REG_START && pwdata[START_FW])
         fw_pend <= 1'b1;
      else if (start_now)
         fw_pend <= 1'b0;
   end

   // optional synchroniser; trigger rides along so settings stay aligned with it
   afcp_cfg_sync #(
      .W ($bits(afcp_cfg_t) + 1)
   ) u_cfg_sync (
      .clk      (clk),
      .srst     (srst),
      .d_in     ({trigger_in, cfg_in}),
      .sync_out (sync_word)
   );
   assign cfg_sync = sync_word[4:0];
   assign cfg_eff  = ctrl[CTRL_SYNC] ? cfg_sync : cfg_in;
   assign trig_eff = ctrl[CTRL_SYNC] ? sync_word[5] : trigger_in;

   always_comb begin
      fab_sw                        = 32'h0000_0000;
      fab_sw[SW_PIN_P_LSB +: 8]     = pin_connect_in;
      fab_sw[SW_PIN_N_LSB +: 8]     = pin_connect_in;
      fab_sw[SW_VSSA]               = switch_ctrl_in[0];
      fab_sw[SW_TEMP]               = switch_ctrl_in[1];
      fab_sw[SW_BUS_P_LSB +: 4]     = bus_connect_in;
      fab_sw[SW_BUS_N_LSB +: 4]     = bus_connect_in;
      fab_sw[SW_TEST]               = 1'b0;
   end

   assign next_sw = sw_fw & (~sw_hw | (fabric_mode ? fab_sw : 32'h0000_0000));

   always_comb begin
      next_ref_neg = 1'b0;
      if (ctrl[CTRL_NEG_LSB +: 3] == NEG_REF_CODE) begin
         if (!ctrl[CTRL_REF_HW])
            next_ref_neg = 1'b1;
         else
            next_ref_neg = fabric_mode & reference_negative_in;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         switch_enable_out         <= 32'h0000_0000;
         reference_negative_en_out <= 1'b0;
      end else begin
         switch_enable_out         <= next_sw;
         reference_negative_en_out <= next_ref_neg;
      end
   end

   // any trigger source, fabric mode, idle only
   assign start_now = fabric_mode && state == ST_IDLE &&
                      (trig_eff || fw_pend || ctrl[CTRL_CONT]);

   always_ff @(posedge clk) begin
      if (srst) begin
         state    <= ST_IDLE;
         hold_cnt <= 2'd0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_now)
                  state <= ST_SAMPLE;
            end
            ST_SAMPLE: begin
               if (adc_sample_done)
                  state <= ST_CONVERT;
            end
            ST_CONVERT: begin
               hold_cnt <= 2'd0;
               if (adc_conv_done)
                  state <= ST_PRESENT;
            end
            ST_PRESENT: begin
               if (hold_cnt == HOLD_CYCLES)
                  state <= ST_IDLE;
               else
                  hold_cnt <= hold_cnt + 2'd1;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         conv_start <= 1'b0;
         conv_req   <= '0;
      end else begin
         conv_start <= start_now;
         if (start_now) begin
            conv_req.sample_cycles <= st_times[cfg_eff.st_sel*8 +: 8];
            conv_req.res           <= pick_res(cfg_eff.average, cfg_eff.resolution, ctrl[CTRL_ALT_RES]);
            conv_req.average       <= cfg_eff.average;
            conv_req.differential  <= cfg_eff.differential;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         result_q     <= 16'h0000;
         sat_q        <= 1'b0;
         range_q      <= 1'b0;
         work_valid   <= 1'b0;
         result_valid <= 1'b0;
      end else if (state == ST_CONVERT && adc_conv_done) begin
         result_q     <= adc_result;
         sat_q        <= adc_sat;
         range_q      <= adc_range;
         work_valid   <= 1'b0;
         result_valid <= 1'b1;
      end else if (start_now) begin
         work_valid <= 1'b0;
      end
   end

   // raw flags, set wins over write-one clear
   always_ff @(posedge clk) begin
      if (srst) begin
         raw_flags <= 2'b00;
      end else begin
         if (state == ST_CONVERT && adc_conv_done)
            raw_flags <= raw_flags | {adc_range, adc_sat};
         else if (wr_en && paddr == REG_FLAGS)
            raw_flags <= raw_flags & ~pwdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         sample_done_out <= 1'b0;
      else
         sample_done_out <= state == ST_SAMPLE && adc_sample_done;
   end

   // early channel number, held two cycles
   always_ff @(posedge clk) begin
      if (srst)
         early_cnt <= 2'd0;
      else if (state == ST_SAMPLE && adc_sample_done)
         early_cnt <= HOLD_CYCLES;
      else if (early_cnt != 2'd0)
         early_cnt <= early_cnt - 2'd1;
   end

   // data two cycles after completion, two cycles wide
   assign data_phase = state == ST_PRESENT && hold_cnt != HOLD_CYCLES &&
                       (fabric_mode || ch0_cfg[CH0_OUT_EN]);

   always_ff @(posedge clk) begin
      if (srst) begin
         data_valid_out           <= 1'b0;
         eos_out                  <= 1'b0;
         channel_number_valid_out <= 1'b0;
         channel_number_out       <= 4'h0;
      end else begin
         data_valid_out           <= data_phase;
         eos_out                  <= data_phase;
         channel_number_valid_out <= data_phase || (state == ST_SAMPLE && adc_sample_done) ||
                                     early_cnt > 2'd1;
         if (data_phase)
            channel_number_out <= {2'b00, range_q, sat_q};
         else
            channel_number_out <= 4'h0;
      end
   end

   // low twelve bits, or high byte combinationally
   assign data_out = data_hilo_sel_in ? {4'h0, result_q[15:8]} : result_q[11:0];

   mode_gate_a: assert property (conv_start |-> $past(fabric_mode))
      else $error("conversion started outside fabric mode");

   sw_gate_a: assert property (switch_enable_out[SW_VSSA] && $past(sw_hw[SW_VSSA]) |->
      $past(fabric_mode && sw_fw[SW_VSSA] && switch_ctrl_in[0]))
      else $error("ground switch on without both enables");

   test_sw_a: assert property (switch_enable_out[SW_TEST] |-> $past(sw_fw[SW_TEST] && !sw_hw[SW_TEST]))
      else $error("test switch driven by fabric");

   ref_code_a: assert property (reference_negative_en_out |-> $past(ctrl[CTRL_NEG_LSB +: 3]) == NEG_REF_CODE)
      else $error("reference switch with wrong negative select");

   avg_res_a: assert property (start_now && cfg_eff.average |=> conv_req.res == AFCP_RES_12)
      else $error("averaging did not force 12-bit");

   chan_early_a: assert property (state == ST_SAMPLE && adc_sample_done |=>
      channel_number_valid_out && channel_number_out == 4'h0 && sample_done_out)
      else $error("early channel number missing");

   data_hold_a: assert property ($rose(data_valid_out) |-> data_valid_out [*2] ##1 !data_valid_out)
      else $error("data valid not held two cycles");

   data_delay_a: assert property (state == ST_CONVERT && adc_conv_done && fabric_mode |-> ##2 $rose(data_valid_out))
      else $error("data not presented after conversion");

   eos_copy_a: assert property (eos_out == data_valid_out)
      else $error("end of scan differs from data valid");

   one_conv_a: assert property (conv_start |=> !conv_start && state != ST_IDLE)
      else $error("second start within one conversion");

   store_both_a: assert property (state == ST_CONVERT && adc_conv_done |=>
      result_q == $past(adc_result) && result_valid)
      else $error("result not stored");

   flag_out_a: assert property (data_valid_out |-> channel_number_out[1:0] == {range_q, sat_q})
      else $error("flags not on channel id with data");

endmodule

// ===== pkg/afcp_pkg.sv
package afcp_pkg;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_CH0_CFG  = 8'h04;
   localparam logic [7:0] REG_START    = 8'h08;
   localparam logic [7:0] REG_SW_FW    = 8'h0c;
   localparam logic [7:0] REG_SW_HW    = 8'h10;
   localparam logic [7:0] REG_ST_TIMES = 8'h14;
   localparam logic [7:0] REG_WORK0    = 8'h18;
   localparam logic [7:0] REG_RESULT0  = 8'h1c;
   localparam logic [7:0] REG_SW_STATE = 8'h20;
   localparam logic [7:0] REG_FLAGS    = 8'h24;

   // Control register fields, plus the channel 0 config and start register bits
   localparam int unsigned CTRL_FABRIC  = 0;
   localparam int unsigned CTRL_SYNC    = 1;
   localparam int unsigned CTRL_ALT_RES = 2;
   localparam int unsigned CTRL_CONT    = 3;
   localparam int unsigned CTRL_NEG_LSB = 9;
   localparam int unsigned CTRL_REF_HW  = 13;
   localparam logic [2:0]  NEG_REF_CODE = 3'h7;
   localparam int unsigned CH0_OUT_EN   = 31;
   localparam int unsigned START_FW     = 0;

   // Switch vector layout, shared by firmware and hardware-enable bits
   localparam int unsigned SW_PIN_P_LSB = 0;
   localparam int unsigned SW_PIN_N_LSB = 8;
   localparam int unsigned SW_VSSA      = 16;
   localparam int unsigned SW_TEMP      = 17;
   localparam int unsigned SW_BUS_P_LSB = 18;
   localparam int unsigned SW_BUS_N_LSB = 22;
   localparam int unsigned SW_TEST      = 30;

   // Result word mirror bits
   localparam int unsigned RES_SAT_BIT   = 29;
   localparam int unsigned RES_RANGE_BIT = 30;
   localparam int unsigned RES_VALID_BIT = 31;
   localparam int unsigned FLAG_SAT      = 0;
   localparam int unsigned FLAG_RANGE    = 1;

   // Reset values
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] CH0_CFG_RST  = 32'h0000_0000;
   localparam logic [31:0] SW_RST       = 32'h0000_0000;
   localparam logic [31:0] ST_TIMES_RST = 32'h0f0f_0f0f;

   // Output strobes stand this many cycles
   localparam logic [1:0] HOLD_CYCLES = 2'd2;

   typedef enum logic [1:0] {
      AFCP_RES_12 = 2'b00,
      AFCP_RES_10 = 2'b01,
      AFCP_RES_8  = 2'b10
   } afcp_res_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b11,
      ST_PRESENT = 2'b10
   } afcp_state_t;

   typedef struct packed {
      logic [1:0] st_sel;
      logic       average;
      logic       resolution;
      logic       differential;
   } afcp_cfg_t;

   typedef struct packed {
      logic [7:0] sample_cycles;
      afcp_res_t  res;
      logic       average;
      logic       differential;
   } afcp_conv_req_t;

endpackage

// ===== rtl/afcp_cfg_sync.sv
module afcp_cfg_sync #(
   parameter int unsigned W = 5
) (
   input  wire logic         clk,      // System clock
   input  wire logic         srst,     // Synchronous reset
   input  wire logic [W-1:0] d_in,     // Asynchronous fabric level
   output logic      [W-1:0] sync_out  // Level in clk domain
);

   logic [W-1:0] stage1;

   always_ff @(posedge clk) begin
      if (srst) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= d_in;
         sync_out <= stage1;
      end
   end

endmodule

// ===== verification/afcp_adc_model.sv
module afcp_adc_model (
   input  wire logic        clk,                    // System clock
   input  wire logic        conv_start,             // Start pulse from sequencer
   output logic             adc_sample_done = 1'b0, // Sampling done pulse
   output logic             adc_conv_done = 1'b0,   // Result ready pulse
   output logic      [15:0] adc_result,             // Result, valid with done
   output logic             adc_sat,                // Saturation flag
   output logic             adc_range               // Range flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   logic [3:0] n = 4'h0;
   logic [15:0] val;
   assign val = 16'ha5c3 ^ {4{n}};
   // Outside the done pulse the result lines show scrambled values
   assign adc_result = adc_conv_done ? val : ~val;
   assign adc_sat = adc_conv_done ? n[0] : ~n[0];
   assign adc_range = adc_conv_done ? n[1] : ~n[1];
   always @(posedge clk) begin
      adc_sample_done <= (cnt == 4'h3);
      adc_conv_done <= (cnt == 4'h7);
      if (conv_start) cnt <= 4'h1;
      else if (cnt == 4'h7) cnt <= 4'h0;
      else if (cnt != 4'h0) cnt <= cnt + 4'h1;
      if (adc_conv_done) n <= n + 4'h1;
   end
endmodule

// ===== verification/tb.sv
module tb;
   import afcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] fw, hw; logic [7:0] p; logic [3:0] b; logic [1:0] s; logic [31:0] x;} afcp_row_t;
   afcp_row_t rows[4] = '{'{'1, 0, 0, 0, 0, '1}, '{'1, '1, 8'h01, 0, 2'b01, 32'h00010101},
      '{32'h1, '1, 8'hff, 0, 0, 32'h1}, '{'1, '1, '1, '1, '1, 32'h03ffffff}};
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, reference_negative_in = 0;
   logic trigger_in = 0, data_hilo_sel_in = 0, pready, pslverr, reference_negative_en_out, conv_start;
   logic adc_sample_done, adc_conv_done, adc_sat, adc_range, sample_done_out;
   logic channel_number_valid_out, data_valid_out, eos_out;
   logic [7:0] paddr = 0, pin_connect_in = 0;
   logic [31:0] pwdata = 0, prdata, switch_enable_out, r;
   logic [3:0] bus_connect_in = 0, channel_number_out;
   logic [1:0] switch_ctrl_in = 0;
   logic [15:0] adc_result;
   logic [11:0] data_out;
   logic e;
   afcp_cfg_t cfg_in = '0;
   afcp_conv_req_t conv_req;
   int err_count = 0, n_checks = 0, ns = 0, ne = 0;
   afcp_top dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .pin_connect_in, .bus_connect_in, .switch_ctrl_in, .reference_negative_in, .cfg_in, .trigger_in,
      .data_hilo_sel_in, .switch_enable_out, .reference_negative_en_out, .conv_start, .conv_req,
      .adc_sample_done, .adc_conv_done, .adc_result, .adc_sat, .adc_range, .sample_done_out,
      .channel_number_valid_out, .channel_number_out, .data_valid_out, .data_out, .eos_out);
   afcp_adc_model adc (.clk, .conv_start, .adc_sample_done, .adc_conv_done, .adc_result, .adc_sat, .adc_range);
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (!srst) begin
         ns += (conv_start === 1'b1);
         ne += (eos_out === 1'b1);
      end
   end
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] g, x);
      n_checks++;
      if (g !== x) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d);
      chk(e, 0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
      apb(0, a, 0);
      chk(r & m, x);
   endtask
   task automatic wt(ref logic s);
      int t = 0;
      while (s !== 1'b1 && t < 100) begin
         @(posedge clk);
         t++;
      end
      if (t >= 100) begin
         err_count++;
         close_out;
      end
   endtask
   task automatic conv(input int k);
      logic [15:0] v;
      logic [1:0] rs;
      v = 16'ha5c3 ^ {4{k[3:0]}};
      rs = (k == 3 || k == 0) ? 2'b00 : (k[1] ? 2'b01 : 2'b10);
      wr(REG_CTRL, {29'h0, k[1], k[0], 1'b1});
      cfg_in <= '{k[1:0], k == 3, k != 0, k[0]};
      if (k == 3) wr(REG_START, 1);
      else begin
         trigger_in <= 1;
         @(posedge clk) trigger_in <= 0;
      end
      wt(conv_start);
      chk(conv_req, {k[3:0] + 4'h1, 4'h0, rs, k == 3, k[0]});
      wt(sample_done_out);
      chk({channel_number_valid_out, channel_number_out}, 5'h10);
      cfg_in <= '1;
      wt(data_valid_out);
      chk({data_valid_out, eos_out, channel_number_valid_out, channel_number_out, data_out},
          {3'b111, 2'b0, k[1], k[0], v[11:0]});
      data_hilo_sel_in <= 1;
      @(posedge clk);
      chk({data_valid_out, eos_out, data_out[7:0]}, {2'b11, v[15:8]});
      data_hilo_sel_in <= 0;
      @(posedge clk);
      chk({data_valid_out, eos_out}, 0);
      rd(REG_WORK0, 32'hffff, v);
      rd(REG_RESULT0, 32'he000ffff, {1'b1, k[1], k[0], 13'h0, v});
      rd(REG_FLAGS, 3, k[1:0]);
      wr(REG_FLAGS, 3);
   endtask
   initial begin
      #200000;
      err_count++;
      close_out;
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      rd(REG_CTRL, '1, 0);
      rd(REG_ST_TIMES, '1, 32'h0f0f0f0f);
      apb(0, 8'h28, 0);
      chk({e, r}, {1'b1, 32'h0});
      wr(REG_SW_FW, '1);
      wr(REG_SW_HW, '1);
      pin_connect_in <= 8'hff;
      trigger_in <= 1;
      @(posedge clk) trigger_in <= 0;
      repeat (20) @(posedge clk);
      chk({ns, switch_enable_out}, 0);
      wr(REG_CTRL, 1);
      foreach (rows[i]) begin
         wr(REG_SW_FW, rows[i].fw);
         wr(REG_SW_HW, rows[i].hw);
         pin_connect_in <= rows[i].p;
         bus_connect_in <= rows[i].b;
         switch_ctrl_in <= rows[i].s;
         repeat (2) @(posedge clk);
         chk(switch_enable_out, rows[i].x);
      end
      wr(REG_CTRL, 32'h2e01);
      reference_negative_in <= 1;
      repeat (2) @(posedge clk);
      chk(reference_negative_en_out, 1);
      reference_negative_in <= 0;
      repeat (2) @(posedge clk);
      chk(reference_negative_en_out, 0);
      wr(REG_CTRL, 32'h2601);
      reference_negative_in <= 1;
      repeat (2) @(posedge clk);
      chk(reference_negative_en_out, 0);
      wr(REG_ST_TIMES, 32'h40302010);
      wr(REG_CH0_CFG, 32'h80000000);
      for (int k = 0; k < 4; k++) conv(k);
      wr(REG_CTRL, 9);
      repeat (60) @(posedge clk);
      wr(REG_CTRL, 1);
      repeat (20) @(posedge clk);
      chk(ne, 2 * ns);
      chk(ns > 6, 1);
      close_out;
   end
endmodule
